// ### rtl/analyzer_clocking_pkg.sv
// Purpose: Shared types and constants for the analyzer input clocking block
// Assumes: System clock of 50 MHz; all counts derive from the period below
// Notes:   Byte groups travel as packed structs

package analyzer_clocking_pkg;

    // System clock period and the fixed delay of the delayed cycle clock
    localparam int unsigned CLK_PERIOD_NS  = 20;
    localparam int unsigned CYCLE_DELAY_NS = 100;
    // Least time, so round up; never less than one cycle
    localparam int unsigned CYCLE_DELAY_CYCLES =
        ((CYCLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS) < 1 ? 1 :
        ((CYCLE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Widths and positions
    localparam int unsigned BYTE_W        = 8;
    localparam int unsigned ADDR_W        = 20;
    localparam int unsigned LOW_ADDR_W    = 16;
    localparam int unsigned RAM_SEL_BIT   = 16;
    localparam int unsigned PAGE_LSB      = 17;
    localparam int unsigned PAGE_W        = 3;

    // Values after reset
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [19:0] ADDR_RESET    = 20'h00000;

    typedef logic [BYTE_W-1:0] byte_t;

    // Bytes captured on the main cycle clock
    typedef struct packed {
        byte_t highDataByte;
        byte_t dataByte;
        byte_t lowAddressByte;
    } cycleBytes_t;

    // Control byte: cycle type above, latched top address below
    typedef struct packed {
        logic [3:0] cycleType;
        logic [3:0] topAddress;
    } controlByte_t;

endpackage : analyzer_clocking_pkg

// ### rtl/sync_bits.sv
// Purpose: Two-stage synchroniser for a group of level signals
// Assumes: Inputs come from another clock domain or a pin
// Notes:   First stage is read only by the second stage

`timescale 1ns/10ps

module sync_bits #(
    parameter int unsigned WIDTH = 1
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            stage1_q <= '0;
            q        <= '0;
        end else begin
            stage1_q <= d;
            q        <= stage1_q;
        end
    end

endmodule : sync_bits

// ### rtl/cycle_capture.sv
// Purpose: Byte registers clocked by the main cycle clock from the target
// Assumes: The cycle clock may stop between bus cycles
// Notes:   Each capture flips a toggle that the system domain follows

`timescale 1ns/10ps

module cycle_capture (
    // Link clock and system reset
    input  wire logic                              cycleClk,
    input  wire logic                              rst_n,
    // Bytes from the target bus
    input  wire analyzer_clocking_pkg::byte_t      lowAddressIn,
    input  wire analyzer_clocking_pkg::byte_t      dataIn,
    input  wire analyzer_clocking_pkg::byte_t      highDataIn,
    // Captured bytes and capture toggle
    output analyzer_clocking_pkg::cycleBytes_t     bytes_q,
    output logic                                   captureToggle_q
);

    logic [1:0] resetSync_q;

    // Reset brought onto the cycle clock
    always_ff @(posedge cycleClk) begin
        resetSync_q <= {resetSync_q[0], rst_n};
    end

    // Capture on the rising edge, hold until the next one
    always_ff @(posedge cycleClk) begin
        if (!resetSync_q[1]) begin
            bytes_q <= '0;
        end else begin
            bytes_q.lowAddressByte <= lowAddressIn;
            bytes_q.dataByte       <= dataIn;
            bytes_q.highDataByte   <= highDataIn;
        end
    end

    always_ff @(posedge cycleClk) begin
        if (!resetSync_q[1]) begin
            captureToggle_q <= 1'b0;
        end else begin
            captureToggle_q <= ~captureToggle_q;
        end
    end

endmodule : cycle_capture

// ### rtl/analyzer_input_clocking.sv
// Purpose: Front end of a bus monitor: capture clocks, byte registers,
//          emulator address latch and target control lines
// Assumes: clk at 50 MHz; main cycle clock is its own domain; all pins but
//          resetRequest, interruptRequest and the cycle bytes pass two flip-flops before use
// Notes:   Summary of operation below

`timescale 1ns/10ps

module analyzer_input_clocking (
    // System clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    // Main cycle clock from the target, link domain
    input  wire logic                                 mainCycleClock,
    // Bus strobes and auxiliary clocks, active low
    input  wire logic                                 readStrobeN,
    input  wire logic                                 writeStrobeN,
    input  wire logic                                 auxClockInA,
    input  wire logic                                 auxClockInB,
    // Dedicated byte clocks
    input  wire logic                                 controlByteClock,
    input  wire logic                                 highAddressByteClock,
    input  wire logic                                 miscByteClock,
    // Analyzer byte inputs
    input  wire analyzer_clocking_pkg::byte_t         miscIn,
    input  wire logic [3:0]                           cycleTypeIn,
    input  wire logic [3:0]                           topAddressIn,
    input  wire analyzer_clocking_pkg::byte_t         highAddressIn,
    input  wire analyzer_clocking_pkg::byte_t         lowAddressIn,
    input  wire analyzer_clocking_pkg::byte_t         dataIn,
    input  wire analyzer_clocking_pkg::byte_t         highDataIn,
    // Emulator address
    input  wire logic                                 addressLatchEnable,
    input  wire logic [15:0]                          emuAddressIn,
    input  wire logic                                 ramSelectAddressIn,
    input  wire logic [2:0]                           pageSelectIn,
    // Emulation memory
    input  wire logic                                 emulatorMasterEnableN,
    input  wire logic                                 emuMapHit,
    input  wire analyzer_clocking_pkg::byte_t         emuReadData,
    // Requests from the instrument
    input  wire logic                                 resetRequest,
    input  wire logic                                 interruptRequest,
    input  wire logic                                 idleLoopActive,
    input  wire logic                                 spareInverterIn,
    // Derived clocks
    output logic                                      strobeOrAuxClock,
    output logic                                      strobePairClock,
    output logic                                      delayedCycleClock,
    // Captured bytes
    output analyzer_clocking_pkg::byte_t              miscByte,
    output analyzer_clocking_pkg::controlByte_t       controlByte,
    output analyzer_clocking_pkg::byte_t              highAddressByte,
    output analyzer_clocking_pkg::cycleBytes_t        cycleBytes,
    output logic                                      cycleCaptured,
    output logic [15:0]                               analyzerCycleCount,
    // Latched emulator address
    output logic                                      addressLatchEnableN,
    output logic [15:0]                               latchedAddressOut,
    output logic [3:0]                                latchedTopAddressOut,
    output logic                                      ramEnable,
    // Emulation memory data bus
    output analyzer_clocking_pkg::byte_t              emuDataOut,
    output logic                                      emuDataOe,
    output logic                                      emulationAccessFlag,
    // Open-collector target lines
    output logic                                      targetResetLineOut,
    output logic                                      targetResetLineOe,
    output logic                                      targetInterruptOut,
    output logic                                      targetInterruptOe,
    // Indicators
    output logic                                      idleN,
    output logic                                      spareInverterOut
);

    localparam int unsigned DLY = analyzer_clocking_pkg::CYCLE_DELAY_CYCLES;

    // Pin synchronisers
    localparam int unsigned CTL_W = 13;
    localparam int unsigned DAT_W = 8 * 2 + 4 + 4 + 20 + 8;

    logic [CTL_W-1:0] ctlRaw;
    logic [CTL_W-1:0] ctlSync;
    logic [DAT_W-1:0] datRaw;
    logic [DAT_W-1:0] datSync;

    assign ctlRaw = {mainCycleClock, readStrobeN, writeStrobeN,
                     auxClockInA, auxClockInB, controlByteClock,
                     highAddressByteClock, miscByteClock,
                     addressLatchEnable, emulatorMasterEnableN,
                     emuMapHit, idleLoopActive, spareInverterIn};
    assign datRaw = {miscIn, highAddressIn, cycleTypeIn, topAddressIn,
                     pageSelectIn, ramSelectAddressIn, emuAddressIn,
                     emuReadData};

    sync_bits #(.WIDTH(CTL_W)) u_ctlSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (ctlRaw),
        .q     (ctlSync)
    );

    sync_bits #(.WIDTH(DAT_W)) u_datSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (datRaw),
        .q     (datSync)
    );

    // Named views of the synchronised pins
    logic        cycleLvl;
    logic        rdN;
    logic        wrN;
    logic        auxA;
    logic        auxB;
    logic        ctlClk;
    logic        hiAddrClk;
    logic        miscClk;
    logic        aleLvl;
    logic        masterEnN;
    logic        mapHit;
    logic        idleLvl;
    logic        invIn;
    logic [7:0]  miscS;
    logic [7:0]  hiAddrS;
    logic [3:0]  cycleTypeS;
    logic [3:0]  topAddrS;
    logic [19:0] addrS;
    logic [7:0]  readDataS;

    assign {cycleLvl, rdN, wrN, auxA, auxB, ctlClk, hiAddrClk, miscClk,
            aleLvl, masterEnN, mapHit, idleLvl, invIn} = ctlSync;
    assign {miscS, hiAddrS, cycleTypeS, topAddrS, addrS, readDataS} =
           datSync;

    // Previous levels of the dedicated byte clocks for edge detection
    logic ctlClkPrev_q;
    logic hiAddrClkPrev_q;
    logic miscClkPrev_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctlClkPrev_q    <= 1'b0;
            hiAddrClkPrev_q <= 1'b0;
            miscClkPrev_q   <= 1'b0;
        end else begin
            ctlClkPrev_q    <= ctlClk;
            hiAddrClkPrev_q <= hiAddrClk;
            miscClkPrev_q   <= miscClk;
        end
    end

    // Strobe-derived clocks
    logic combinedStrobe;

    assign combinedStrobe = rdN | wrN;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strobeOrAuxClock <= 1'b1;
            strobePairClock  <= 1'b1;
        end else begin
            strobeOrAuxClock <= combinedStrobe | (auxA & auxB);
            strobePairClock  <= ~(rdN & wrN);
        end
    end

    // Delayed, inverted copy of the main cycle clock
    logic [DLY-1:0] delayLine_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            delayLine_q <= '0;
        end else begin
            delayLine_q <= {delayLine_q[DLY-2:0], cycleLvl};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            delayedCycleClock <= 1'b1;
        end else begin
            delayedCycleClock <= ~delayLine_q[DLY-1];
        end
    end

    // Bytes on their own dedicated clocks; tie to main clock if unused
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            controlByte <= '0;
        end else if (ctlClk && !ctlClkPrev_q) begin
            controlByte.cycleType  <= cycleTypeS;
            controlByte.topAddress <= topAddrS;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            highAddressByte <= analyzer_clocking_pkg::BYTE_RESET;
        end else if (hiAddrClk && !hiAddrClkPrev_q) begin
            highAddressByte <= hiAddrS;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            miscByte <= analyzer_clocking_pkg::BYTE_RESET;
        end else if (miscClk && !miscClkPrev_q) begin
            miscByte <= miscS;
        end
    end

    // Bytes on the main cycle clock, carried across by a toggle
    analyzer_clocking_pkg::cycleBytes_t linkBytes;
    logic                               linkToggle;
    logic                               toggleSync;
    logic                               togglePrev_q;

    cycle_capture u_cycleCapture (
        .cycleClk        (mainCycleClock),
        .rst_n           (rst_n),
        .lowAddressIn    (lowAddressIn),
        .dataIn          (dataIn),
        .highDataIn      (highDataIn),
        .bytes_q         (linkBytes),
        .captureToggle_q (linkToggle)
    );

    sync_bits #(.WIDTH(1)) u_toggleSync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (linkToggle),
        .q     (toggleSync)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            togglePrev_q <= 1'b0;
        end else begin
            togglePrev_q <= toggleSync;
        end
    end

    // Bytes are stable two edges before the toggle is seen here
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycleBytes <= '0;
        end else if (toggleSync != togglePrev_q) begin
            cycleBytes <= linkBytes;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cycleCaptured <= 1'b0;
        end else begin
            cycleCaptured <= (toggleSync != togglePrev_q);
        end
    end

    // Sequencing count of analyzer cycles
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            analyzerCycleCount <= 16'h0000;
        end else if (toggleSync != togglePrev_q) begin
            analyzerCycleCount <= analyzerCycleCount + 16'h0001;
        end
    end

    // Emulator address latch, transparent while enable is high
    logic [19:0] addrLatch_q;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addrLatch_q <= analyzer_clocking_pkg::ADDR_RESET;
        end else if (aleLvl) begin
            addrLatch_q <= addrS;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addressLatchEnableN  <= 1'b1;
            latchedAddressOut    <= 16'h0000;
            latchedTopAddressOut <= 4'h0;
            ramEnable            <= 1'b0;
        end else begin
            addressLatchEnableN  <= ~aleLvl;
            latchedAddressOut    <= addrLatch_q[15:0];
            latchedTopAddressOut <= addrLatch_q[19:16];
            ramEnable            <= addrLatch_q[
                analyzer_clocking_pkg::RAM_SEL_BIT];
        end
    end

    // Emulation memory data bus, off while master enable is high
    logic emuAccess;

    assign emuAccess = !masterEnN && mapHit;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            emuDataOut          <= analyzer_clocking_pkg::BYTE_RESET;
            emuDataOe           <= 1'b0;
            emulationAccessFlag <= 1'b0;
        end else begin
            emuDataOut          <= readDataS;
            emuDataOe           <= emuAccess;
            emulationAccessFlag <= emuAccess;
        end
    end

    // Open-collector lines only ever pull low
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            targetResetLineOut <= 1'b0;
            targetResetLineOe  <= 1'b0;
            targetInterruptOut <= 1'b0;
            targetInterruptOe  <= 1'b0;
        end else begin
            targetResetLineOut <= 1'b0;
            targetResetLineOe  <= resetRequest;
            targetInterruptOut <= 1'b0;
            targetInterruptOe  <= interruptRequest;
        end
    end

    // Indicators
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idleN            <= 1'b1;
            spareInverterOut <= 1'b1;
        end else begin
            idleN            <= ~idleLvl;
            spareInverterOut <= ~invIn;
        end
    end

endmodule : analyzer_input_clocking

// ### testbench/analyzer_input_clocking_checker.sv
// Purpose: Port-level checks of the analyzer input clocking block
// Assumes: Synchronised pin paths answer three clk edges after the pin, request lines one
// Notes:   Bound to the top module below

`timescale 1ns/10ps

module analyzer_input_clocking_checker (
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // Watched inputs
    input wire logic        readStrobeN,
    input wire logic        writeStrobeN,
    input wire logic        auxClockInA,
    input wire logic        auxClockInB,
    input wire logic        addressLatchEnable,
    input wire logic        spareInverterIn,
    input wire logic        emulatorMasterEnableN,
    input wire logic        emuMapHit,
    input wire logic        resetRequest,
    input wire logic        interruptRequest,
    // Watched outputs
    input wire logic        strobeOrAuxClock,
    input wire logic        strobePairClock,
    input wire logic        cycleCaptured,
    input wire logic [15:0] analyzerCycleCount,
    input wire logic        addressLatchEnableN,
    input wire logic        emuDataOe,
    input wire logic        emulationAccessFlag,
    input wire logic        targetResetLineOut,
    input wire logic        targetResetLineOe,
    input wire logic        targetInterruptOut,
    input wire logic        targetInterruptOe,
    input wire logic        spareInverterOut
);
    logic [2:0] settleCnt_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // Synchroniser stages hold reset values just after release
    always_ff @(posedge clk) begin
        if (!rst_n)
            settleCnt_q <= 3'h0;
        else if (settleCnt_q != 3'h7)
            settleCnt_q <= settleCnt_q + 3'h1;
    end

    sequence captureStep;
        cycleCaptured ##1 !cycleCaptured;
    endsequence

    chk_strobe_or_term: assert property (settleCnt_q >= 3'h4 |->
        strobeOrAuxClock == ($past(readStrobeN, 3) | $past(writeStrobeN, 3)
        | ($past(auxClockInA, 3) & $past(auxClockInB, 3))))
        else $error("strobe or aux clock wrong");
    chk_strobe_pair: assert property (settleCnt_q >= 3'h4 |->
        strobePairClock == !($past(readStrobeN, 3) && $past(writeStrobeN, 3)))
        else $error("strobe pair clock wrong");
    chk_ale_inverse: assert property (settleCnt_q >= 3'h4 |->
        addressLatchEnableN == !$past(addressLatchEnable, 3))
        else $error("inverted latch enable wrong");
    chk_spare_inverter: assert property (settleCnt_q >= 3'h4 |->
        spareInverterOut == !$past(spareInverterIn, 3))
        else $error("spare inverter wrong");
    chk_emu_enable: assert property (settleCnt_q >= 3'h4 |->
        emuDataOe == (!$past(emulatorMasterEnableN, 3) && $past(emuMapHit, 3))
        && emulationAccessFlag == emuDataOe)
        else $error("emulation enable wrong");
    chk_reset_pull: assert property (settleCnt_q >= 3'h1 |->
        targetResetLineOe == $past(resetRequest) && !targetResetLineOut)
        else $error("target reset line wrong");
    chk_irq_pull: assert property (settleCnt_q >= 3'h1 |->
        targetInterruptOe == $past(interruptRequest) && !targetInterruptOut)
        else $error("target interrupt line wrong");
    chk_capture_count: assert property (cycleCaptured |->
        analyzerCycleCount == $past(analyzerCycleCount) + 16'h1)
        else $error("cycle count step wrong");
    chk_capture_pulse: assert property (cycleCaptured |-> captureStep)
        else $error("capture pulse too long");
endmodule : analyzer_input_clocking_checker

bind analyzer_input_clocking analyzer_input_clocking_checker
    i_analyzer_input_clocking_checker (.*);

// ### testbench/target_bus_model.sv
// Purpose: Target bus model: main cycle clock and captured bus bytes
// Assumes: Link clock of 12 ns, still between frames
// Notes:   Released bus shows the inverse of the last bytes

`timescale 1ns/10ps

module target_bus_model (
    // Link clock and bus bytes toward the block
    output logic                               mainCycleClock,
    output analyzer_clocking_pkg::cycleBytes_t busBytes
);
    initial begin
        mainCycleClock = 1'b0;
        busBytes = 24'h000000;
    end

    task automatic pulses(input int n);
        repeat (n) begin
            #6 mainCycleClock = 1'b1;
            #6 mainCycleClock = 1'b0;
        end
    endtask : pulses

    task automatic frame(input analyzer_clocking_pkg::cycleBytes_t v,
                         input int highNs);
        busBytes = v;
        #6 mainCycleClock = 1'b1;
        #(highNs) mainCycleClock = 1'b0;
        #6 busBytes = ~v;
        #80;
    endtask : frame
endmodule : target_bus_model

// ### testbench/analyzer_input_clocking_tb_top.sv
// Purpose: Self-checking bench of the analyzer input clocking block
// Assumes: Inputs change at the falling clk edge
// Notes:   One task a scenario

`timescale 1ns/10ps

module analyzer_input_clocking_tb_top;
    logic clk, rst_n, mainCycleClock, readStrobeN, writeStrobeN;
    logic auxClockInA, auxClockInB, controlByteClock, highAddressByteClock;
    logic miscByteClock, addressLatchEnable, ramSelectAddressIn;
    logic emulatorMasterEnableN, emuMapHit, resetRequest, interruptRequest;
    logic idleLoopActive, spareInverterIn, strobeOrAuxClock, strobePairClock;
    logic delayedCycleClock, cycleCaptured, addressLatchEnableN, ramEnable;
    logic emuDataOe, emulationAccessFlag, targetResetLineOut, idleN;
    logic targetResetLineOe, targetInterruptOut, targetInterruptOe;
    logic spareInverterOut;
    logic [3:0] cycleTypeIn, topAddressIn, latchedTopAddressOut;
    logic [2:0] pageSelectIn;
    logic [15:0] emuAddressIn, analyzerCycleCount, latchedAddressOut;
    analyzer_clocking_pkg::byte_t miscIn, highAddressIn, lowAddressIn;
    analyzer_clocking_pkg::byte_t dataIn, highDataIn, emuReadData;
    analyzer_clocking_pkg::byte_t miscByte, highAddressByte, emuDataOut;
    analyzer_clocking_pkg::controlByte_t controlByte;
    analyzer_clocking_pkg::cycleBytes_t cycleBytes, busBytes;
    int fails = 0;
    int numChecks = 0;
    int cycles = 0;

    analyzer_input_clocking i_analyzer_input_clocking (.*);
    target_bus_model i_target_bus_model (
        .mainCycleClock (mainCycleClock),
        .busBytes       (busBytes)
    );
    assign lowAddressIn = busBytes.lowAddressByte;
    assign dataIn = busBytes.dataByte;
    assign highDataIn = busBytes.highDataByte;

    always #10 clk = ~clk;

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", numChecks, fails);
        if (fails == 0 && numChecks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc

    task automatic t_strobes;
        logic [3:0] v;
        for (int i = 0; i < 16; i++) begin
            v = 4'(i);
            {readStrobeN, writeStrobeN, auxClockInA, auxClockInB} = v;
            cyc(4);
            check("orClk", 32'(v[3] | v[2] | (v[1] & v[0])),
                  32'(strobeOrAuxClock));
            check("pairClk", 32'(!(v[3] & v[2])), 32'(strobePairClock));
        end
    endtask : t_strobes

    task automatic t_pins;
        for (int i = 0; i < 2; i++) begin
            {spareInverterIn, idleLoopActive, resetRequest} = {3{i[0]}};
            interruptRequest = !i[0];
            emulatorMasterEnableN = !i[0];
            emuMapHit = 1'b1;
            emuReadData = 8'ha5 ^ {8{i[0]}};
            cyc(5);
            check("inv", 32'(!i[0]), 32'(spareInverterOut));
            check("idle", 32'(!i[0]), 32'(idleN));
            check("rstOe", 32'(i[0]), 32'(targetResetLineOe));
            check("irqOe", 32'(!i[0]), 32'(targetInterruptOe));
            check("ocOut", 32'h0, 32'({targetResetLineOut,
                  targetInterruptOut}));
            check("emuOe", 32'(i[0]), 32'(emuDataOe));
            check("access", 32'(i[0]), 32'(emulationAccessFlag));
        end
        check("emuData", 32'h5a, 32'(emuDataOut));
        emuMapHit = 1'b0;
        cyc(5);
        check("emuOeMiss", 32'h0, 32'(emuDataOe));
    endtask : t_pins

    task automatic t_latch;
        addressLatchEnable = 1'b1;
        emuAddressIn = 16'h1234;
        ramSelectAddressIn = 1'b1;
        pageSelectIn = 3'h5;
        cyc(5);
        check("aleN", 32'h0, 32'(addressLatchEnableN));
        check("addr", 32'h1234, 32'(latchedAddressOut));
        check("top", 32'hb, 32'(latchedTopAddressOut));
        check("ram", 32'h1, 32'(ramEnable));
        addressLatchEnable = 1'b0;
        cyc(5);
        emuAddressIn = 16'hedcb;
        {pageSelectIn, ramSelectAddressIn} = 4'h4;
        cyc(5);
        check("aleN", 32'h1, 32'(addressLatchEnableN));
        check("addrHeld", 32'hb1234, 32'({latchedTopAddressOut,
              latchedAddressOut}));
    endtask : t_latch

    task automatic t_bytes;
        {miscIn, cycleTypeIn, topAddressIn, highAddressIn} = 24'h3c96c3;
        cyc(2);
        {controlByteClock, highAddressByteClock, miscByteClock} = 3'h7;
        cyc(4);
        check("bytes", 32'h3c96c3, 32'({miscByte, controlByte,
              highAddressByte}));
        {miscIn, cycleTypeIn, topAddressIn, highAddressIn} = 24'h5a0f18;
        cyc(4);
        check("held", 32'h3c96c3, 32'({miscByte, controlByte,
              highAddressByte}));
        {controlByteClock, highAddressByteClock, miscByteClock} = 3'h0;
        cyc(3);
        miscByteClock = 1'b1;
        cyc(4);
        check("miscOnly", 32'h5a96c3, 32'({miscByte, controlByte,
              highAddressByte}));
    endtask : t_bytes

    task automatic t_cycles;
        analyzer_clocking_pkg::cycleBytes_t v;
        int n;
        check("dlyIdle", 32'h1, 32'(delayedCycleClock));
        for (int i = 0; i < 3; i++) begin
            v = 24'h5a3c96 + 24'h111111 * 24'(i);
            fork
                i_target_bus_model.frame(v, (i == 2) ? 300 : 6);
                begin
                    n = 0;
                    @(posedge mainCycleClock);
                    while (cycleCaptured !== 1'b1 && n < 12) begin
                        @(posedge clk);
                        #1;
                        n++;
                    end
                    check("cycBytes", 32'(v), 32'(cycleBytes));
                    check("count", 32'(i + 1), 32'(analyzerCycleCount));
                    while (i == 2 && delayedCycleClock !== 1'b0 && n < 20) begin
                        @(posedge clk);
                        #1;
                        n++;
                    end
                    if (i == 2)
                        check("delay", 32'h1, 32'(n >= 5 && n <= 10));
                end
            join
        end
        cyc(12);
        check("dlyBack", 32'h1, 32'(delayedCycleClock));
    endtask : t_cycles

    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {readStrobeN, writeStrobeN, auxClockInA, auxClockInB} = 4'hf;
        {controlByteClock, highAddressByteClock, miscByteClock} = 3'h0;
        {miscIn, cycleTypeIn, topAddressIn, highAddressIn} = 24'h000000;
        {addressLatchEnable, emuAddressIn} = 17'h00000;
        {ramSelectAddressIn, pageSelectIn} = 4'h0;
        {emulatorMasterEnableN, emuMapHit, emuReadData} = 10'h200;
        {resetRequest, interruptRequest} = 2'h0;
        {idleLoopActive, spareInverterIn} = 2'h0;
        i_target_bus_model.pulses(4);
        cyc(3);
        rst_n = 1'b1;
        // Link-side reset releases only on link edges
        i_target_bus_model.pulses(2);
        cyc(1);
        t_strobes();
        t_pins();
        t_latch();
        t_bytes();
        t_cycles();
        report_and_stop();
    end
endmodule : analyzer_input_clocking_tb_top
